// *** include/smc_pkg.sv ***
// Constants for the sleep-mode clock gating controller.
// Assumes a single 50 MHz system clock and a synchronous active-low reset.
package smc_pkg;
    // ***************************************************
    // Sleep mode codes
    // ***************************************************
    localparam logic [2:0] SMC_MODE_IDLE = 3'h0;
    localparam logic [2:0] SMC_MODE_NOISE = 3'h1;
    localparam logic [2:0] SMC_MODE_PDOWN = 3'h2;
    localparam logic [2:0] SMC_MODE_PSAVE = 3'h3;
    localparam logic [2:0] SMC_MODE_RSV4 = 3'h4;
    localparam logic [2:0] SMC_MODE_RSV5 = 3'h5;
    localparam logic [2:0] SMC_MODE_STBY = 3'h6;
    localparam logic [2:0] SMC_MODE_XSTBY = 3'h7;

    // ***************************************************
    // Timing counts
    // ***************************************************
    localparam int SMC_HALT_CYCLES = 4;
    localparam int SMC_STBY_WAKE_CYCLES = 6;
    localparam int SMC_CNT_W = 16;
    localparam logic [SMC_CNT_W-1:0] SMC_CNT_ZERO = 16'h0000;
    localparam logic [SMC_CNT_W-1:0] SMC_CNT_ONE = 16'h0001;

    // ***************************************************
    // Wake source vector bit positions
    // ***************************************************
    localparam int SMC_WK_CONV = 0;
    localparam int SMC_WK_TWI = 1;
    localparam int SMC_WK_ATMR = 2;
    localparam int SMC_WK_NVM = 3;
    localparam int SMC_WK_EXT_LVL01 = 4;
    localparam int SMC_WK_EXT2 = 5;
    localparam int SMC_WK_EXT_EDGE01 = 6;
    localparam int SMC_WK_CMP = 7;
    localparam int SMC_WK_OTHER = 8;
    localparam int SMC_WK_N = 9;

    typedef enum {SMC_RUN, SMC_SLEEP, SMC_START, SMC_HALT} smc_state_e;
endpackage

// *** hdl/smc_sync.sv ***
// Two flip-flop synchroniser for a vector of asynchronous levels.
// Assumes inputs are levels held longer than two clock cycles.
`timescale 1ns/1ps
module smc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } smc_sync_s;

    smc_sync_s state_reg;
    smc_sync_s state_next;

    always_comb begin
        state_next.first = async_in;
        state_next.second = state_reg.first;
    end

    // Reset keeps sleep wake lines quiet until released
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.second;
endmodule

// *** hdl/smc_ctrl.sv ***
// Sleep-mode controller: decodes the mode code, gates the clock domains and
// sequences the wake-up. Assumes the core pulses sleep_instr for one cycle and
// stalls while core_halt is high; gated clocks are made by latch-free cells
// driven from these enables, which change only just after a rising edge of clk.
`timescale 1ns/1ps
module smc_ctrl import smc_pkg::*; #(
    parameter int STARTUP_W = SMC_CNT_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic sleep_enable,
    input wire logic [2:0] sleep_mode_code,
    input wire logic sleep_instr,
    input wire logic async_timer_clock_on,
    input wire logic comparator_power_off,
    input wire logic converter_enable,
    input wire logic crystal_selected,
    input wire logic [SMC_CNT_W-1:0] startup_cycles,
    input wire logic irq_pending,
    input wire logic global_irq_enable,
    input wire logic atmr_irq_enable,
    input wire logic wake_conv,
    input wire logic wake_atmr,
    input wire logic wake_nvm,
    input wire logic wake_other,
    input wire logic wake_cmp,
    input wire logic ext_irq_line_0,
    input wire logic ext_irq_line_1,
    input wire logic ext_irq_line_2,
    input wire logic ext01_level_mode,
    input wire logic two_wire_port_match,
    input wire logic sys_reset_req,
    output logic cpu_clk_en,
    output logic flash_clk_en,
    output logic io_clk_en,
    output logic conv_clk_en,
    output logic async_clk_en,
    output logic main_osc_en,
    output logic timer_osc_en,
    output logic core_halt,
    output logic conv_start,
    output logic irq_service,
    output logic restart_from_vector,
    output logic asleep
);
    initial begin
        if (STARTUP_W != SMC_CNT_W) begin
            $error("STARTUP_W must equal the start-up counter width");
        end
    end

    // ***************************************************
    // Wake line synchronisers
    // ***************************************************
    logic [SMC_WK_N-1:0] wake_raw;
    logic [SMC_WK_N-1:0] wake_s;
    logic ext_level01;
    logic ext_edge01;

    assign ext_level01 = ext01_level_mode & (ext_irq_line_0 | ext_irq_line_1);
    assign ext_edge01 = ~ext01_level_mode & (ext_irq_line_0 | ext_irq_line_1);
    always_comb begin
        wake_raw = '0;
        wake_raw[SMC_WK_CONV] = wake_conv;
        wake_raw[SMC_WK_TWI] = two_wire_port_match;
        wake_raw[SMC_WK_ATMR] = wake_atmr;
        wake_raw[SMC_WK_NVM] = wake_nvm;
        wake_raw[SMC_WK_EXT_LVL01] = ext_level01;
        wake_raw[SMC_WK_EXT2] = ext_irq_line_2;
        wake_raw[SMC_WK_EXT_EDGE01] = ext_edge01;
        wake_raw[SMC_WK_CMP] = wake_cmp;
        wake_raw[SMC_WK_OTHER] = wake_other;
    end

    smc_sync #(
        .WIDTH(SMC_WK_N)
    ) u_wake_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(wake_raw),
        .sync_out(wake_s)
    );

    // ***************************************************
    // State
    // ***************************************************
    typedef struct packed {
        smc_state_e fsm;
        logic [2:0] mode;
        logic [SMC_CNT_W-1:0] cnt;
        logic conv_start;
        logic service;
        logic rst_wake;
        logic [6:0] clk_en;
    } smc_ctrl_s;

    smc_ctrl_s state_reg;
    smc_ctrl_s state_next;

    // Clock enables packed as cpu, flash, io, conv, async, main osc, timer osc
    function automatic logic [6:0] gate_for(input logic [2:0] m, input logic as2, input logic xtal);
        logic [6:0] g;
        g = 7'h00;
        case (m)
            SMC_MODE_IDLE: g = {2'b00, 1'b1, 1'b1, 1'b1, 1'b1, as2};
            SMC_MODE_NOISE: g = {2'b00, 1'b0, 1'b1, 1'b1, 1'b1, as2};
            SMC_MODE_PDOWN: g = 7'h00;
            SMC_MODE_PSAVE: g = {5'b00001, 1'b0, as2} & {4'b0000, as2, 1'b0, 1'b1};
            SMC_MODE_STBY: g = {5'b00000, xtal, 1'b0};
            SMC_MODE_XSTBY: g = {4'b0000, as2, xtal, as2};
            default: g = 7'h00;
        endcase
        return g;
    endfunction

    // Wake qualification per mode; level-only external lines in deep modes
    function automatic logic wake_ok(input logic [2:0] m, input logic [SMC_WK_N-1:0] w, input logic gie,
        input logic tie, input logic acd);
        logic deep_ext;
        logic atmr;
        deep_ext = w[SMC_WK_EXT2] | w[SMC_WK_EXT_LVL01];
        atmr = w[SMC_WK_ATMR] & gie & tie;
        case (m)
            SMC_MODE_IDLE: wake_ok = |(w & ~(SMC_WK_N'(acd) << SMC_WK_CMP));
            SMC_MODE_NOISE: wake_ok = w[SMC_WK_CONV] | w[SMC_WK_TWI] | w[SMC_WK_ATMR] | w[SMC_WK_NVM] | deep_ext;
            SMC_MODE_PDOWN, SMC_MODE_STBY: wake_ok = w[SMC_WK_TWI] | deep_ext;
            SMC_MODE_PSAVE, SMC_MODE_XSTBY: wake_ok = w[SMC_WK_TWI] | deep_ext | atmr;
            default: wake_ok = w[SMC_WK_TWI] | deep_ext;
        endcase
    endfunction

    logic wake_hit;
    assign wake_hit = wake_ok(state_reg.mode, wake_s, global_irq_enable, atmr_irq_enable, comparator_power_off);

    // ***************************************************
    // Next state
    // ***************************************************
    always_comb begin
        state_next = state_reg;
        state_next.conv_start = 1'b0;
        state_next.service = 1'b0;
        case (state_reg.fsm)
            SMC_RUN: begin
                state_next.rst_wake = 1'b0;
                state_next.clk_en = 7'h7f;
                if (sleep_instr && sleep_enable) begin
                    state_next.fsm = SMC_SLEEP;
                    state_next.mode = sleep_mode_code;
                    state_next.clk_en = gate_for(sleep_mode_code, async_timer_clock_on, crystal_selected);
                    state_next.conv_start = converter_enable &&
                        (sleep_mode_code == SMC_MODE_IDLE || sleep_mode_code == SMC_MODE_NOISE);
                end
            end
            SMC_SLEEP: begin
                if (wake_hit) begin
                    state_next.fsm = SMC_START;
                    state_next.clk_en[1] = 1'b1;
                    state_next.clk_en[2] = 1'b1;
                    if (state_reg.mode == SMC_MODE_STBY || state_reg.mode == SMC_MODE_XSTBY) begin
                        state_next.cnt = SMC_CNT_W'(SMC_STBY_WAKE_CYCLES);
                    end else if (state_reg.mode == SMC_MODE_IDLE || state_reg.mode == SMC_MODE_NOISE) begin
                        state_next.cnt = SMC_CNT_ONE;
                    end else begin
                        state_next.cnt = (startup_cycles == SMC_CNT_ZERO) ? SMC_CNT_ONE : startup_cycles;
                    end
                end
            end
            SMC_START: begin
                state_next.clk_en[1] = 1'b1;
                state_next.clk_en[2] = 1'b1;
                state_next.clk_en[3] = 1'b1;
                state_next.clk_en[4] = 1'b1;
                if (state_reg.cnt == SMC_CNT_ONE) begin
                    state_next.fsm = SMC_HALT;
                    state_next.cnt = SMC_CNT_W'(SMC_HALT_CYCLES);
                end else begin
                    state_next.cnt = state_reg.cnt - SMC_CNT_ONE;
                end
            end
            SMC_HALT: begin
                if (state_reg.cnt == SMC_CNT_ONE) begin
                    state_next.fsm = SMC_RUN;
                    state_next.clk_en = 7'h7f;
                    state_next.service = irq_pending;
                end else begin
                    state_next.cnt = state_reg.cnt - SMC_CNT_ONE;
                end
            end
            default: state_next.fsm = SMC_RUN;
        endcase
        if (sys_reset_req && state_reg.fsm != SMC_RUN) begin
            state_next.fsm = SMC_RUN;
            state_next.clk_en = 7'h7f;
            state_next.rst_wake = 1'b1;
            state_next.service = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg.fsm <= SMC_RUN;
            state_reg.mode <= SMC_MODE_IDLE;
            state_reg.cnt <= SMC_CNT_ZERO;
            state_reg.conv_start <= 1'b0;
            state_reg.service <= 1'b0;
            state_reg.rst_wake <= 1'b0;
            state_reg.clk_en <= 7'h7f;
        end else begin
            state_reg <= state_next;
        end
    end

    // ***************************************************
    // Outputs
    // ***************************************************
    // enables change on rising edge, gates sample on low phase
    // no data state is touched, only clocks stopped
    assign {cpu_clk_en, flash_clk_en, io_clk_en, conv_clk_en, async_clk_en, main_osc_en, timer_osc_en} =
        state_reg.clk_en;
    assign core_halt = (state_reg.fsm != SMC_RUN);
    assign asleep = (state_reg.fsm == SMC_SLEEP);
    assign conv_start = state_reg.conv_start;
    assign irq_service = state_reg.service;
    assign restart_from_vector = state_reg.rst_wake;

    // ***************************************************
    // Checks
    // ***************************************************
    a_sleep_needs_en: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg.fsm == SMC_RUN && sleep_instr && !sleep_enable && !sys_reset_req) |=> !core_halt)
        else $error("sleep entered without enable");
    a_idle_clocks: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && state_reg.mode == SMC_MODE_IDLE) |-> (!cpu_clk_en && !flash_clk_en && io_clk_en && conv_clk_en))
        else $error("idle gating wrong");
    a_noise_clocks: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && state_reg.mode == SMC_MODE_NOISE) |-> (!io_clk_en && conv_clk_en && async_clk_en))
        else $error("noise gating wrong");
    a_pdown_off: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && state_reg.mode == SMC_MODE_PDOWN) |-> (state_reg.clk_en == 7'h00))
        else $error("power-down clocks on");
    a_halt_four: assert property (@(posedge clk) disable iff (!reset_n)
        ($rose(state_reg.fsm == SMC_HALT)) |-> core_halt [*4] ##1 !core_halt)
        else $error("halt count wrong");
    a_stby_six: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && wake_hit && !sys_reset_req && state_reg.mode == SMC_MODE_STBY) |=>
        (state_reg.fsm == SMC_START) [*6] ##1 (state_reg.fsm == SMC_HALT))
        else $error("standby wake not six cycles");
    a_conv_entry: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg.fsm == SMC_RUN && sleep_instr && sleep_enable && converter_enable && !sys_reset_req &&
        sleep_mode_code == SMC_MODE_IDLE) |=> conv_start)
        else $error("conversion not started");
    a_reset_wake: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && sys_reset_req) |=> (restart_from_vector && !core_halt && !irq_service))
        else $error("reset wake wrong");
    a_gated_release: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg.fsm == SMC_START) |-> !cpu_clk_en)
        else $error("core clock before delay");
    // ***************************************************
    // Checks on mode gating, wake qualification, conversion start and the service pulse
    // ***************************************************
    a_psave_clocks: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && state_reg.mode == SMC_MODE_PSAVE) |-> (state_reg.clk_en[6:3] == 4'h0 && !main_osc_en))
        else $error("power-save gating wrong");
    a_timer_osc_off: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg.fsm == SMC_RUN && sleep_instr && sleep_enable && !sys_reset_req && !async_timer_clock_on) |=>
        !timer_osc_en)
        else $error("timer oscillator on without enable");
    a_stby_osc: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg.fsm == SMC_RUN && sleep_instr && sleep_enable && !sys_reset_req &&
        sleep_mode_code == SMC_MODE_STBY) |=> (main_osc_en == $past(crystal_selected) && !io_clk_en))
        else $error("standby oscillator wrong");
    a_xstby_six: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && wake_hit && !sys_reset_req && state_reg.mode == SMC_MODE_XSTBY) |=>
        (state_reg.fsm == SMC_START) [*6] ##1 (state_reg.fsm == SMC_HALT))
        else $error("extended standby wake not six cycles");
    a_reserved_off: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && (state_reg.mode == SMC_MODE_RSV4 || state_reg.mode == SMC_MODE_RSV5)) |->
        (state_reg.clk_en == 7'h00))
        else $error("reserved code clocks on");
    a_conv_noise: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg.fsm == SMC_RUN && sleep_instr && sleep_enable && converter_enable && !sys_reset_req &&
        sleep_mode_code == SMC_MODE_NOISE) |=> conv_start)
        else $error("noise conversion not started");
    a_conv_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg.fsm == SMC_RUN && sleep_instr && sleep_enable && !sys_reset_req &&
        (!converter_enable || sleep_mode_code > SMC_MODE_NOISE)) |=> !conv_start)
        else $error("conversion started wrongly");
    a_noise_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && state_reg.mode == SMC_MODE_NOISE && !sys_reset_req && !wake_s[SMC_WK_CONV] &&
        !wake_s[SMC_WK_TWI] && !wake_s[SMC_WK_ATMR] && !wake_s[SMC_WK_NVM] && !wake_s[SMC_WK_EXT2] &&
        !wake_s[SMC_WK_EXT_LVL01]) |=> asleep)
        else $error("noise mode woke on a stray source");
    a_pdown_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && (state_reg.mode == SMC_MODE_PDOWN || state_reg.mode == SMC_MODE_STBY) && !sys_reset_req &&
        !wake_s[SMC_WK_TWI] && !wake_s[SMC_WK_EXT2] && !wake_s[SMC_WK_EXT_LVL01]) |=> asleep)
        else $error("power-down woke on a stray source");
    a_psave_timer: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && state_reg.mode == SMC_MODE_PSAVE && !(global_irq_enable && atmr_irq_enable) &&
        !sys_reset_req && !wake_s[SMC_WK_TWI] && !wake_s[SMC_WK_EXT2] && !wake_s[SMC_WK_EXT_LVL01]) |=> asleep)
        else $error("timer woke without both enables");
    a_deep_edge: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && state_reg.mode != SMC_MODE_IDLE && !sys_reset_req &&
        wake_s == (SMC_WK_N'(1) << SMC_WK_EXT_EDGE01)) |=> asleep)
        else $error("edge line woke deep sleep");
    a_idle_cmp: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && state_reg.mode == SMC_MODE_IDLE && comparator_power_off && !sys_reset_req &&
        wake_s == (SMC_WK_N'(1) << SMC_WK_CMP)) |=> asleep)
        else $error("comparator woke while powered off");
    a_idle_wake: assert property (@(posedge clk) disable iff (!reset_n)
        (asleep && state_reg.mode == SMC_MODE_IDLE && wake_s[SMC_WK_OTHER] && !sys_reset_req) |=>
        (state_reg.fsm == SMC_START))
        else $error("idle ignored an interrupt");
    a_halt_clocks: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg.fsm == SMC_HALT) |-> (!cpu_clk_en && !flash_clk_en))
        else $error("core clock during halt");
    a_service_once: assert property (@(posedge clk) disable iff (!reset_n)
        irq_service |=> !irq_service)
        else $error("service pulse too long");
    a_run_clocks: assert property (@(posedge clk) disable iff (!reset_n)
        (state_reg.fsm == SMC_RUN) |-> (state_reg.clk_en == 7'h7f))
        else $error("clock gated while running");
endmodule

// *** testbench/smc_core_model.sv ***
// Partner model: the core and the interrupt sources around the controller.
// Assumes bench commands change just after a rising edge of clk.
`timescale 1ns/1ps
module smc_core_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic go,
    input wire logic use_en,
    input wire logic fire,
    input wire logic drop,
    input wire logic [8:0] src,
    input wire logic asleep,
    input wire logic irq_service,
    output logic sleep_enable = 1'h0,
    output logic sleep_instr = 1'h0,
    output logic irq_pending,
    output logic [8:0] lines = 9'h000
);
    // ****************************
    // Core and interrupt sources
    // ****************************
    logic armed_reg = 1'h0;

    // No timer state read back
    // Pending flag shown only once clocks run, so it never acts as a wake line
    assign irq_pending = (|lines) && !asleep;

    always @(posedge clk) begin
        if (!reset_n) begin
            sleep_enable <= 1'h0;
            sleep_instr <= 1'h0;
            armed_reg <= 1'h0;
            lines <= 9'h000;
        end else begin
            armed_reg <= go;
            sleep_instr <= armed_reg;
            if (go) begin
                sleep_enable <= use_en;
            end else if (irq_service) begin
                sleep_enable <= 1'h0;
            end
            if (drop || irq_service) begin
                lines <= 9'h000;
            end else if (fire) begin
                lines <= src;
            end
        end
    end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the sleep-mode controller.
// Assumes the partner model stands in for the core and interrupt sources.
`timescale 1ns/1ps
module tb_top
    import smc_pkg::*;
;
    // ***************
    // Stimulus state
    // ***************
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic [2:0] mode = 3'h0;
    logic as2 = 1'h0, cmp_off = 1'h0, conv_en = 1'h1, xtal = 1'h1, gie = 1'h1, tmr_ie = 1'h1;
    logic lvl01 = 1'h1, sys_rst = 1'h0, go = 1'h0, use_en = 1'h1, fire = 1'h0, drop = 1'h0;
    logic [8:0] src = 9'h000;
    logic [15:0] startup = 16'h000a;
    logic se, si, ipend, svc, rfv, asl, halt, cst;
    logic [8:0] wl;
    logic [6:0] en;
    int bad_count = 0;
    int check_count = 0;
    int nsrc[6] = '{0, 1, 2, 5, 7, 8};

    always #10 clk = ~clk;

    smc_ctrl uut (
        .clk(clk), .reset_n(reset_n), .sleep_enable(se), .sleep_mode_code(mode), .sleep_instr(si),
        .async_timer_clock_on(as2), .comparator_power_off(cmp_off), .converter_enable(conv_en),
        .crystal_selected(xtal), .startup_cycles(startup), .irq_pending(ipend), .global_irq_enable(gie),
        .atmr_irq_enable(tmr_ie), .wake_conv(wl[0]), .wake_atmr(wl[1]), .wake_nvm(wl[2]), .wake_other(wl[3]),
        .wake_cmp(wl[4]), .ext_irq_line_0(wl[5]), .ext_irq_line_1(wl[6]), .ext_irq_line_2(wl[7]),
        .ext01_level_mode(lvl01), .two_wire_port_match(wl[8]), .sys_reset_req(sys_rst),
        .cpu_clk_en(en[6]), .flash_clk_en(en[5]), .io_clk_en(en[4]), .conv_clk_en(en[3]),
        .async_clk_en(en[2]), .main_osc_en(en[1]), .timer_osc_en(en[0]), .core_halt(halt),
        .conv_start(cst), .irq_service(svc), .restart_from_vector(rfv), .asleep(asl)
    );

    smc_core_model core (
        .clk(clk), .reset_n(reset_n), .go(go), .use_en(use_en), .fire(fire), .drop(drop), .src(src),
        .asleep(asl), .irq_service(svc), .sleep_enable(se), .sleep_instr(si), .irq_pending(ipend), .lines(wl)
    );

    // ***************
    // Shared helpers
    // ***************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // Order: cpu, flash, io, conv, async, main osc, timer osc
    function automatic logic [6:0] exp_en(input logic [2:0] m);
        case (m)
            3'h0: return {4'h3, 2'h3, as2};
            3'h1: return {4'h1, 2'h3, as2};
            3'h3: return {4'h0, as2, 1'h0, as2};
            3'h6: return {4'h0, 1'h0, xtal, 1'h0};
            3'h7: return {4'h0, as2, xtal, as2};
            default: return 7'h00;
        endcase
    endfunction

    task automatic enter(input logic [2:0] m, input logic e);
        mode = m;
        use_en = e;
        go = 1'h1;
        tick(1);
        go = 1'h0;
        tick(2);
        chk(asl === e, "sleep entry");
        chk(cst === (e && conv_en && m <= 3'h1), "conversion start");
        chk(en === (e ? exp_en(m) : 7'h7f), "clock enables");
    endtask

    task automatic raise(input int b);
        src = 9'h000;
        src[b] = 1'h1;
        fire = 1'h1;
        tick(1);
        fire = 1'h0;
    endtask

    task automatic wake(input int b, input int n);
        int c;
        int g;
        int k;
        c = 0;
        g = 0;
        k = 0;
        raise(b);
        while (halt !== 1'h0 && k < 2000) begin
            if (asl === 1'h0) c++;
            if (asl === 1'h0 && en[6] !== 1'h0) g++;
            tick(1);
            k++;
        end
        chk(c == n + SMC_HALT_CYCLES, "wake-up delay");
        chk(g == 0 && svc === 1'h1 && en === 7'h7f, "release and service");
    endtask

    // Line stays up, so a correct design must still be asleep
    task automatic no_wake(input int b);
        raise(b);
        tick(12);
        chk(asl === 1'h1 && halt === 1'h1, "stray wake");
        drop = 1'h1;
        tick(1);
        drop = 1'h0;
        tick(4);
    endtask

    // **********
    // Scenarios
    // **********
    task automatic t_modes;
        for (int a = 0; a < 2; a++) begin
            as2 = a[0];
            for (int m = 0; m < 8; m++) begin
                enter(m[2:0], 1'h1);
                wake(7, m < 2 ? 1 : (m > 5 ? SMC_STBY_WAKE_CYCLES : int'(startup)));
            end
        end
        $display("test modes done");
    endtask

    task automatic t_sources;
        enter(SMC_MODE_IDLE, 1'h1);
        wake(3, 1);
        cmp_off = 1'h1;
        enter(SMC_MODE_IDLE, 1'h1);
        no_wake(4);
        wake(3, 1);
        cmp_off = 1'h0;
        enter(SMC_MODE_IDLE, 1'h1);
        wake(4, 1);
        as2 = 1'h1;
        for (int i = 0; i < 6; i++) begin
            enter(SMC_MODE_NOISE, 1'h1);
            if (i == 0) no_wake(3);
            wake(nsrc[i], 1);
        end
        enter(SMC_MODE_PDOWN, 1'h1);
        lvl01 = 1'h0;
        no_wake(5);
        no_wake(2);
        no_wake(0);
        lvl01 = 1'h1;
        wake(6, int'(startup));
        enter(SMC_MODE_PSAVE, 1'h1);
        no_wake(3);
        tmr_ie = 1'h0;
        no_wake(1);
        tmr_ie = 1'h1;
        gie = 1'h0;
        no_wake(1);
        gie = 1'h1;
        wake(1, int'(startup));
        enter(SMC_MODE_PDOWN, 1'h1);
        wake(8, int'(startup));
        $display("test sources done");
    endtask

    task automatic t_reset;
        enter(SMC_MODE_XSTBY, 1'h1);
        sys_rst = 1'h1;
        tick(1);
        sys_rst = 1'h0;
        chk(halt === 1'h0 && rfv === 1'h1 && en === 7'h7f, "reset wake");
        enter(SMC_MODE_IDLE, 1'h1);
        chk(rfv === 1'h0, "vector flag left set");
        wake(7, 1);
        xtal = 1'h0;
        conv_en = 1'h0;
        enter(SMC_MODE_STBY, 1'h1);
        wake(7, SMC_STBY_WAKE_CYCLES);
        enter(SMC_MODE_IDLE, 1'h1);
        wake(7, 1);
        xtal = 1'h1;
        conv_en = 1'h1;
        enter(SMC_MODE_PDOWN, 1'h0);
        tick(5);
        chk(halt === 1'h0 && asl === 1'h0, "sleep without enable");
        $display("test reset and disabled sleep done");
    endtask

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard at 50,000 cycles, far beyond the fewer than 1,000 cycles the tests need
    initial begin
        #1_000_000;
        bad_count++;
        give_verdict;
    end

    initial begin
        tick(3);
        chk(en === 7'h7f && halt === 1'h0 && asl === 1'h0, "reset state");
        reset_n = 1'h1;
        tick(1);
        t_modes;
        t_sources;
        t_reset;
        give_verdict;
    end
endmodule
